// >>> core/ced_timing.sv
// Edge timing generator and external sync tracker of the CCD processor
//
// Contract
// - Pixel period holds 48 positions, 0 to 47
// - Two top code bits pick the quadrant
// - Low four bits give offset 0 to 11
// - Reset gate rises at 0, falls programmed
// - Horizontal clock A falls 24 after rise
// - Horizontal clock B inverts clock A
// - Sample clocks sit at their own positions
// - Data changes at phase, opposite 24 later
// - Strobe code picks fixed rise/fall pairs
// - Data and strobe phases set independently
// - Drive code zero three-states the output
// - Master mode aligns sync to external pulse
// - Follower bit zero makes pin sync input
// - Follower mode after reset
// - Sync polarity bit, active low default
// - Count zero disables, one syncs every pulse
// - Counts 2 to 14 sync after N pulses
// - Count 15 syncs on first pulse only
// - Sync count applied at vertical sync fall
// - Other writes apply at load strobe rise
`timescale 1ns/1ns
`include "ced_map.svh"
module ced_timing (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial register port
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic serial_load_strobe,
    // Pixel reference and sync pins
    input wire logic master_clock_in,
    input wire logic external_sync_gate_pin,
    input wire logic vertical_sync,
    // Pixel data path
    input wire logic [9:0] pixel_data_in,
    output logic [9:0] pixel_data_out,
    output logic pixel_data_phase,
    output logic output_data_strobe,
    // Sensor clocks
    output logic reset_gate_clock,
    output logic horizontal_clock_a,
    output logic horizontal_clock_b,
    output logic reference_sample_clock,
    output logic level_sample_clock,
    // Driver strength and enables
    output logic [2:0] hclk_a_drive,
    output logic [2:0] hclk_b_drive,
    output logic [2:0] reset_gate_drive,
    output logic hclk_a_oe,
    output logic hclk_b_oe,
    output logic reset_gate_oe,
    // Counter alignment pulse to the sync counters
    output logic sync_align
);
    import ced_pkg::*;

    ced_wr_t wr;
    logic wr_valid;

    // Register write decoding from the serial port
    ced_serial u_serial (
        .clock(clock),
        .rst(rst),
        .serial_clock(serial_clock),
        .serial_data(serial_data),
        .serial_load_strobe(serial_load_strobe),
        .wr(wr),
        .wr_valid(wr_valid)
    );

    // Register state
    logic ext_sync_polarity, next_polarity;
    logic [5:0] ref_sample_position, next_ref;
    logic [5:0] data_sample_position, next_lvl;
    logic [5:0] output_data_phase, next_dphase;
    logic [1:0] output_strobe_phase, next_strobe;
    logic [5:0] reset_gate_fall_position, next_rg_fall;
    logic [5:0] hclk_rise_position, next_hrise;
    logic [2:0] next_ha_drv, next_hb_drv, next_rg_drv;
    logic [3:0] ext_sync_count_select, next_count_sel;
    logic [3:0] pending_count, next_pending_count;
    logic pending, next_pending;
    logic follower_mode_select, next_follower;
    logic vd_prev;
    logic vd_fall;
    logic count_apply;

    assign vd_fall = vd_prev && !vertical_sync;
    assign count_apply = vd_fall && pending;

    // sync count held until vertical sync falls
    always_comb begin
        next_polarity = ext_sync_polarity;
        next_ref = ref_sample_position;
        next_lvl = data_sample_position;
        next_dphase = output_data_phase;
        next_strobe = output_strobe_phase;
        next_rg_fall = reset_gate_fall_position;
        next_hrise = hclk_rise_position;
        next_ha_drv = hclk_a_drive;
        next_hb_drv = hclk_b_drive;
        next_rg_drv = reset_gate_drive;
        next_count_sel = ext_sync_count_select;
        next_pending_count = pending_count;
        next_pending = pending;
        next_follower = follower_mode_select;
        // Apply first so a write in the same cycle stays pending
        if (count_apply) begin
            next_count_sel = pending_count;
            next_pending = 1'b0;
        end
        if (wr_valid) begin
            unique case (wr.addr)
                `CED_ADDR_POLARITY: begin
                    next_polarity = wr.data[`CED_POLARITY_BIT];
                end
                `CED_ADDR_SAMPLE: begin
                    next_ref = wr.data[`CED_REF_LSB +: 6];
                    next_lvl = wr.data[`CED_LVL_LSB +: 6];
                    next_dphase = wr.data[`CED_DPHASE_LSB +: 6];
                    next_strobe = wr.data[`CED_STROBE_LSB +: 2];
                end
                `CED_ADDR_EDGE: begin
                    next_rg_fall = wr.data[`CED_RG_FALL_LSB +: 6];
                    next_hrise = wr.data[`CED_HRISE_LSB +: 6];
                end
                `CED_ADDR_DRIVE: begin
                    next_ha_drv = wr.data[`CED_HA_DRV_LSB +: 3];
                    next_hb_drv = wr.data[`CED_HB_DRV_LSB +: 3];
                    next_rg_drv = wr.data[`CED_RG_DRV_LSB +: 3];
                end
                `CED_ADDR_SYNC_COUNT: begin
                    next_pending_count = wr.data[`CED_COUNT_LSB +: 4];
                    next_pending = 1'b1;
                end
                `CED_ADDR_FOLLOWER: begin
                    next_follower = wr.data[`CED_FOLLOWER_BIT];
                end
                default: begin
                    // Addresses owned by other blocks are ignored here
                end
            endcase
        end
    end

    // follower mode and active low polarity at reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_sync_polarity <= `CED_RST_POLARITY;
            ref_sample_position <= `CED_RST_REF;
            data_sample_position <= `CED_RST_LVL;
            output_data_phase <= `CED_RST_DPHASE;
            output_strobe_phase <= `CED_RST_STROBE;
            reset_gate_fall_position <= `CED_RST_RG_FALL;
            hclk_rise_position <= `CED_RST_HRISE;
            hclk_a_drive <= `CED_RST_DRIVE;
            hclk_b_drive <= `CED_RST_DRIVE;
            reset_gate_drive <= `CED_RST_DRIVE;
            ext_sync_count_select <= `CED_RST_COUNT;
            pending_count <= `CED_RST_COUNT;
            pending <= 1'b0;
            follower_mode_select <= `CED_RST_FOLLOWER;
            vd_prev <= 1'b1;
        end else begin
            ext_sync_polarity <= next_polarity;
            ref_sample_position <= next_ref;
            data_sample_position <= next_lvl;
            output_data_phase <= next_dphase;
            output_strobe_phase <= next_strobe;
            reset_gate_fall_position <= next_rg_fall;
            hclk_rise_position <= next_hrise;
            hclk_a_drive <= next_ha_drv;
            hclk_b_drive <= next_hb_drv;
            reset_gate_drive <= next_rg_drv;
            ext_sync_count_select <= next_count_sel;
            pending_count <= next_pending_count;
            pending <= next_pending;
            follower_mode_select <= next_follower;
            vd_prev <= vertical_sync;
        end
    end

    // zero drive code leaves the pin undriven
    assign hclk_a_oe = (hclk_a_drive != 3'h0);
    assign hclk_b_oe = (hclk_b_drive != 3'h0);
    assign reset_gate_oe = (reset_gate_drive != 3'h0);

    // Pin synchronisers for the master clock and the sync pin
    logic [2:0] mclk_q;
    logic [1:0] sync_q;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mclk_q <= 3'h0;
            sync_q <= 2'h3;
        end else begin
            mclk_q <= {mclk_q[1:0], master_clock_in};
            sync_q <= {sync_q[0], external_sync_gate_pin};
        end
    end

    // Position counter; one clock cycle per position
    logic [5:0] pos, next_pos;
    logic mclk_rise;
    assign mclk_rise = mclk_q[1] && !mclk_q[2];

    // restart at zero on each master clock rise
    always_comb begin
        if (mclk_rise || pos == `CED_LAST_POS) begin
            next_pos = 6'h00;
        end else begin
            next_pos = pos + 6'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pos <= 6'h00;
        end else begin
            pos <= next_pos;
        end
    end

    // Decoded edge positions
    logic [5:0] rg_fall_pos, h_rise_pos, ref_pos, lvl_pos, dph_pos;
    logic [5:0] strobe_rise, strobe_fall;

    // quadrant select and offset clamp to 11
    assign rg_fall_pos = ced_pos(reset_gate_fall_position);
    assign h_rise_pos = ced_pos(hclk_rise_position);
    assign ref_pos = ced_pos(ref_sample_position);
    assign lvl_pos = ced_pos(data_sample_position);
    assign dph_pos = ced_pos(output_data_phase);

    // fixed strobe edge pairs per phase code
    always_comb begin
        unique case (output_strobe_phase)
            2'h0: begin
                strobe_rise = `CED_STROBE_P06;
                strobe_fall = `CED_STROBE_P26;
            end
            2'h1: begin
                strobe_rise = `CED_STROBE_P16;
                strobe_fall = `CED_STROBE_P36;
            end
            2'h2: begin
                strobe_rise = `CED_STROBE_P26;
                strobe_fall = `CED_STROBE_P06;
            end
            2'h3: begin
                strobe_rise = `CED_STROBE_P36;
                strobe_fall = `CED_STROBE_P16;
            end
        endcase
    end

    // Edge windows: reset gate, clock A, two samples, strobe, data
    logic [5:0] win_rise [6];
    logic [5:0] win_fall [6];
    logic [5:0] win_level;

    // reset gate fixed rise at zero
    assign win_rise[0] = 6'h00;
    assign win_fall[0] = rg_fall_pos;
    // clock A falls half a period after rise
    assign win_rise[1] = h_rise_pos;
    assign win_fall[1] = ced_add_half(h_rise_pos);
    // sample clocks at their own positions
    assign win_rise[2] = ref_pos;
    assign win_fall[2] = ced_add_half(ref_pos);
    assign win_rise[3] = lvl_pos;
    assign win_fall[3] = ced_add_half(lvl_pos);
    assign win_rise[4] = strobe_rise;
    assign win_fall[4] = strobe_fall;
    // data phase opposite edge half a period on
    assign win_rise[5] = dph_pos;
    assign win_fall[5] = ced_add_half(dph_pos);

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_win
            ced_edge u_edge (
                .clock(clock),
                .rst(rst),
                .pos(pos),
                .rise(win_rise[gi]),
                .fall(win_fall[gi]),
                .level(win_level[gi])
            );
        end
    endgenerate

    assign reset_gate_clock = win_level[0];
    assign horizontal_clock_a = win_level[1];
    // clock B is the exact inverse of clock A
    assign horizontal_clock_b = !win_level[1];
    assign reference_sample_clock = win_level[2];
    assign level_sample_clock = win_level[3];
    assign output_data_strobe = win_level[4];
    assign pixel_data_phase = win_level[5];

    // launch data in step with the phase window rise
    logic [9:0] next_pixel;
    always_comb begin
        next_pixel = (pos == dph_pos) ? pixel_data_in : pixel_data_out;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pixel_data_out <= 10'h000;
        end else begin
            pixel_data_out <= next_pixel;
        end
    end

    // Sync pulse detection; polarity flips the sense of the pin
    // Edge taken on the pin level, so a polarity write makes no pulse
    logic sync_active, sync_prev, sync_evt, master_mode;
    // polarity zero recognises a low pulse
    assign sync_active = ext_sync_polarity ? sync_q[1] : !sync_q[1];
    assign sync_evt = sync_active && (sync_q[1] != sync_prev);
    // follower bit zero turns the pin into the sync input
    assign master_mode = !follower_mode_select;

    ced_sync_state_t state, next_state;
    logic [3:0] sync_cnt, next_sync_cnt;
    logic next_align;

    // align counters to external pulses in master mode
    always_comb begin
        next_state = state;
        next_sync_cnt = sync_cnt;
        next_align = 1'b0;
        if (count_apply) begin
            // rewritten count restarts the pulse count
            next_sync_cnt = 4'h0;
            next_state = (pending_count == 4'h0) ? CED_SY_OFF : CED_SY_COUNT;
        end else begin
            unique case (state)
                CED_SY_OFF: begin
                    if (ext_sync_count_select != 4'h0) begin
                        next_state = CED_SY_COUNT;
                    end
                end
                CED_SY_COUNT: begin
                    if (master_mode && sync_evt) begin
                        if (ext_sync_count_select == `CED_COUNT_ONCE) begin
                            next_align = 1'b1;
                            next_state = CED_SY_DONE;
                        end else if (4'(sync_cnt + 4'h1)
                                     >= ext_sync_count_select) begin
                            next_align = 1'b1;
                            next_sync_cnt = 4'h0;
                        end else begin
                            next_sync_cnt = sync_cnt + 4'h1;
                        end
                    end
                end
                CED_SY_DONE: begin
                    // Later pulses ignored until the count is rewritten
                end
                default: begin
                    next_state = CED_SY_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= CED_SY_OFF;
            sync_cnt <= 4'h0;
            sync_align <= 1'b0;
            sync_prev <= 1'b1;
        end else begin
            state <= next_state;
            sync_cnt <= next_sync_cnt;
            sync_align <= next_align;
            sync_prev <= sync_q[1];
        end
    end

    // Checks on the generated timing
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    chk_pos_wrap: assert property (
        pos == `CED_LAST_POS && !mclk_rise |=> pos == 6'h00)
        else $error("position did not wrap after 47");
    chk_rg_rise: assert property (
        pos == 6'h00 && rg_fall_pos != 6'h00 |=> reset_gate_clock)
        else $error("reset gate not high after position zero");
    chk_hclk_fall: assert property (
        pos == ced_add_half(h_rise_pos) |=> !horizontal_clock_a)
        else $error("clock A not low half a period after rise");
    chk_hclk_inverse: assert property (
        horizontal_clock_b == !horizontal_clock_a)
        else $error("clock B is not the inverse of clock A");
    chk_drive_off: assert property (
        (hclk_a_drive == 3'h0) == !hclk_a_oe)
        else $error("clock A enable disagrees with drive code");
    chk_strobe_code: assert property (
        output_strobe_phase == 2'h1 && pos == 6'h10
        ##1 output_strobe_phase == 2'h1 |-> output_data_strobe)
        else $error("strobe not high at position 16 for code 01");
    chk_follower_quiet: assert property (
        !master_mode |=> !sync_align)
        else $error("alignment pulse while in follower mode");
    chk_sync_off: assert property (
        ext_sync_count_select == 4'h0 |-> !sync_align)
        else $error("alignment pulse with sync disabled");
    chk_every_pulse: assert property (
        state == CED_SY_COUNT && ext_sync_count_select == 4'h1
        && master_mode && sync_evt && !count_apply |=> sync_align)
        else $error("count one did not align on a pulse");
    chk_count_held: assert property (
        !vd_fall |=> $stable(ext_sync_count_select))
        else $error("sync count changed without vertical sync fall");
    chk_once_done: assert property (
        state == CED_SY_DONE && !count_apply |=> !sync_align[*2])
        else $error("alignment after single-shot sync completed");

    cov_align: cover property (sync_align);
    cov_once: cover property (state == CED_SY_DONE);
    cov_count_apply: cover property (count_apply ##1 state == CED_SY_COUNT);
endmodule

// >>> core/ced_map.svh
// Register offsets, field positions, reset values and edge constants
`ifndef CED_MAP_SVH
`define CED_MAP_SVH

// Serial word layout: 8 address bits then 24 data bits
`define CED_FRAME_BITS 6'h20

// Register addresses
`define CED_ADDR_POLARITY 8'h01
`define CED_ADDR_SAMPLE 8'h02
`define CED_ADDR_EDGE 8'h03
`define CED_ADDR_DRIVE 8'h04
`define CED_ADDR_SYNC_COUNT 8'h0a
`define CED_ADDR_FOLLOWER 8'hd6

// Field positions inside the 24-bit data word
`define CED_POLARITY_BIT 0
`define CED_REF_LSB 0
`define CED_LVL_LSB 6
`define CED_DPHASE_LSB 12
`define CED_STROBE_LSB 18
`define CED_RG_FALL_LSB 0
`define CED_HRISE_LSB 6
`define CED_HA_DRV_LSB 0
`define CED_HB_DRV_LSB 3
`define CED_RG_DRV_LSB 6
`define CED_COUNT_LSB 0
`define CED_FOLLOWER_BIT 0

// Reset values
`define CED_RST_POLARITY 1'h0
`define CED_RST_REF 6'h00
`define CED_RST_LVL 6'h20
`define CED_RST_DPHASE 6'h00
`define CED_RST_STROBE 2'h0
`define CED_RST_RG_FALL 6'h10
`define CED_RST_HRISE 6'h00
`define CED_RST_DRIVE 3'h1
`define CED_RST_COUNT 4'h0
`define CED_RST_FOLLOWER 1'h1

// Pixel period geometry and fixed edge figures
`define CED_LAST_POS 6'h2f
`define CED_HALF_PERIOD 6'h18
`define CED_MAX_OFFSET 4'hb
`define CED_COUNT_ONCE 4'hf
`define CED_STROBE_P06 6'h06
`define CED_STROBE_P16 6'h10
`define CED_STROBE_P26 6'h1a
`define CED_STROBE_P36 6'h24

`endif

// >>> core/ced_pkg.sv
// Types and position helpers shared by the edge timing block
`include "ced_map.svh"
package ced_pkg;

    // One complete serial register write
    typedef struct packed {
        logic [7:0] addr;
        logic [23:0] data;
    } ced_wr_t;

    // External sync tracker states
    typedef enum logic [2:0] {
        CED_SY_OFF = 3'b001,
        CED_SY_COUNT = 3'b010,
        CED_SY_DONE = 3'b100
    } ced_sync_state_t;

    // Quadrant code to position: quadrant times 12 plus clamped offset
    function automatic logic [5:0] ced_pos(input logic [5:0] code);
        logic [3:0] off;
        off = (code[3:0] > `CED_MAX_OFFSET) ? `CED_MAX_OFFSET : code[3:0];
        return {1'b0, code[5:4], 3'b000} + {2'b00, code[5:4], 2'b00}
            + {2'b00, off};
    endfunction

    // Position half a pixel period later, wrapping at 48
    function automatic logic [5:0] ced_add_half(input logic [5:0] p);
        return (p >= `CED_HALF_PERIOD) ? (p - `CED_HALF_PERIOD)
            : (p + `CED_HALF_PERIOD);
    endfunction

endpackage

// >>> core/ced_edge.sv
// Registered level that is high from a rise position to a fall position
`timescale 1ns/1ns
module ced_edge (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Position and window
    input wire logic [5:0] pos,
    input wire logic [5:0] rise,
    input wire logic [5:0] fall,
    // Level out
    output logic level
);
    import ced_pkg::*;

    logic next_level;

    // Window may wrap past position 47; equal edges give no pulse
    always_comb begin
        if (rise <= fall) begin
            next_level = (pos >= rise) && (pos < fall);
        end else begin
            next_level = (pos >= rise) || (pos < fall);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end
endmodule

// >>> core/ced_serial.sv
// Three-wire serial write receiver, 8 address bits then 24 data bits
`timescale 1ns/1ns
`include "ced_map.svh"
module ced_serial (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Serial pins
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic serial_load_strobe,
    // Completed write
    output ced_pkg::ced_wr_t wr,
    output logic wr_valid
);
    import ced_pkg::*;

    logic [2:0] sck_q;
    logic [1:0] sd_q;
    logic [2:0] sl_q;
    logic [31:0] shift, next_shift;
    logic [5:0] bits, next_bits;
    ced_wr_t next_wr;
    logic next_valid;

    // Pin synchronisers; only the second stage onward is examined
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_q <= 3'h0;
            sd_q <= 2'h0;
            sl_q <= 3'h7;
        end else begin
            sck_q <= {sck_q[1:0], serial_clock};
            sd_q <= {sd_q[0], serial_data};
            sl_q <= {sl_q[1:0], serial_load_strobe};
        end
    end

    // Shift on clock rise while load is low; commit on load rise
    always_comb begin
        next_shift = shift;
        next_bits = bits;
        next_wr = wr;
        next_valid = 1'b0;
        if (!sl_q[1] && sck_q[1] && !sck_q[2]) begin
            next_shift = {shift[30:0], sd_q[1]};
            if (bits != `CED_FRAME_BITS) begin
                next_bits = bits + 6'h01;
            end
        end
        if (sl_q[1] && !sl_q[2]) begin
            // A short frame is dropped rather than half applied
            next_valid = (bits == `CED_FRAME_BITS);
            next_wr = (bits == `CED_FRAME_BITS) ? shift : wr;
            next_bits = 6'h00;
        end
        if (!sl_q[1] && sl_q[2]) begin
            next_bits = 6'h00;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shift <= 32'h0000_0000;
            bits <= 6'h00;
            wr <= '0;
            wr_valid <= 1'b0;
        end else begin
            shift <= next_shift;
            bits <= next_bits;
            wr <= next_wr;
            wr_valid <= next_valid;
        end
    end
endmodule

// >>> dv/ced_sensor_model.sv
// Pixel reference clock and external sync source
`timescale 1ns/1ns
module ced_sensor_model (
    // Clock and request
    input wire logic clock,
    input wire logic sync_fire,
    // Pins toward the block
    output logic master_clock_in = 1'b0,
    output logic external_sync_gate_pin = 1'b1
);
    int n = 0;
    // Reference of 48 system clocks; sync idles high like a pull-up
    always @(posedge clock) begin
        n <= (n == 47) ? 0 : n + 1;
        master_clock_in <= #1 (n < 24);
        external_sync_gate_pin <= #1 !sync_fire;
    end
endmodule

// >>> dv/ced_timing_tb.sv
// Self-checking bench for the edge timing block
`timescale 1ns/1ns
module ced_timing_tb;
    logic clock = 0, rst = 1, sck = 1, sda = 0, sl = 1, vs = 1, fire = 0;
    logic [9:0] pix = 10'h2a5;
    logic [9:0] pout, hi, rgc;
    logic [2:0] hda, hbd, rgd;
    logic mck, spin, ha, hb, rg, pdp, strb, sa, hoa, hob, rgo, rsc, lsc;
    int n_mismatch = 0, comparisons = 0, at;
    initial forever #5 clock = ~clock;
    ced_sensor_model far (.clock(clock), .sync_fire(fire),
        .master_clock_in(mck), .external_sync_gate_pin(spin));
    ced_timing uut (.clock(clock), .rst(rst), .serial_clock(sck),
        .serial_data(sda), .serial_load_strobe(sl), .master_clock_in(mck),
        .external_sync_gate_pin(spin), .vertical_sync(vs),
        .pixel_data_in(pix), .pixel_data_out(pout),
        .pixel_data_phase(pdp), .output_data_strobe(strb),
        .reset_gate_clock(rg), .horizontal_clock_a(ha),
        .horizontal_clock_b(hb), .reference_sample_clock(rsc),
        .level_sample_clock(lsc), .hclk_a_drive(hda), .hclk_b_drive(hbd),
        .reset_gate_drive(rgd), .hclk_a_oe(hoa), .hclk_b_oe(hob),
        .reset_gate_oe(rgo), .sync_align(sa));
    // Inputs move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // One 32-bit frame, bit taken on each serial clock rise
    task automatic wr(input logic [31:0] w);
        sl = 0;
        for (int i = 31; i >= 0; i--) begin
            sda = w[i];
            sck = 0;
            tick(3);
            sck = 1;
            tick(3);
        end
        sl = 1;
        tick(8);
    endtask
    // Sync pulses; aligns in the release half weigh 16 to expose polarity
    task automatic pulses(input int n, input int exp);
        logic [9:0] got;
        got = 10'h000;
        repeat (2 * n) begin
            fire = !fire;
            repeat (6) begin
                tick(1);
                got += fire ? {9'h000, sa} : {5'h00, sa, 4'h0};
            end
        end
        chk(got, 10'(exp));
    endtask
    task automatic vsf;
        vs = 1;
        tick(2);
        vs = 0;
        tick(2);
    endtask
    // One pixel period from the reset gate rise; index equals position
    task automatic scan(input int sel);
        int k;
        logic p, s;
        k = 0;
        while (rg === 1'b1 && k < 99) begin
            tick(1);
            k++;
        end
        while (rg !== 1'b1 && k < 99) begin
            tick(1);
            k++;
        end
        if (k >= 99) begin
            n_mismatch++;
            stop_test;
        end
        at = 99;
        hi = 0;
        rgc = 0;
        p = 1;
        for (int i = 0; i < 48; i++) begin
            s = (sel == 0) ? ha : (sel == 1) ? pdp : (sel == 2) ? strb
                : (sel == 3) ? rsc : lsc;
            hi += s;
            rgc += rg;
            if (s && !p && at == 99) at = i;
            p = s;
            chk(hb, !ha);
            // Pixel word names the position it stands in
            pix = 10'(i + 1);
            tick(1);
        end
    endtask
    initial begin
        tick(2);
        rst = 0;
        tick(3);
        chk(hda, 3'h1);
        pulses(2, 0);
        wr(32'hd600_0000);
        pulses(2, 0);
        wr(32'h0a00_0003);
        pulses(3, 0);
        vsf();
        pulses(3, 1);
        wr(32'h0a00_000f);
        vsf();
        pulses(3, 1);
        wr(32'h0a00_0001);
        vsf();
        pulses(2, 2);
        wr(32'h0100_0001);
        pulses(2, 32);
        wr(32'h0400_01c7);
        chk({hoa, hob, rgo, hda}, 6'h2f);
        chk({hbd, rgd}, 6'h07);
        wr(32'h0300_089b);
        scan(0);
        chk(rgc, 10'd23);
        chk(at[9:0], 10'd26);
        chk(hi, 10'd24);
        for (int c = 0; c < 4; c++) begin
            wr({8'h02, 4'h0, 2'(c), 6'h05, 6'h2a, 6'h13});
            scan(2);
            chk(at[9:0], 10'(6 + 10 * c));
            chk(hi, (c < 2) ? 10'd20 : 10'd28);
        end
        scan(1);
        chk(at[9:0], 10'd5);
        chk(hi, 10'd24);
        chk(pout, 10'h005);
        scan(3);
        chk(at[9:0], 10'd15);
        scan(4);
        chk(at[9:0], 10'd34);
        chk(hi, 10'd24);
        stop_test;
    end
endmodule
